// [verilog/mtr_params.svh]
// Purpose: Shared constants of the metering DSP control block.
// Assumes: 250 MHz system clock.
// Notes:   Offsets are 16-bit serial-port register addresses.
`ifndef MTR_PARAMS_SVH
`define MTR_PARAMS_SVH

// Register addresses
`define MTR_ADDR_RUN        16'hE228
`define MTR_ADDR_STATUS_FLAGS_ZERO    16'hE502
`define MTR_ADDR_INTERRUPT_MASK_ZERO      16'hE50A
`define MTR_ADDR_CONFIG     16'hE618
`define MTR_ADDR_PROT_CTRL  16'hE7E3
`define MTR_ADDR_PROT_KEY   16'hE7FE
`define MTR_ADDR_CAL_A      16'hE5C0
`define MTR_ADDR_CAL_B      16'hE5C1
`define MTR_ADDR_CAL_C      16'hE5C2
`define MTR_ADDR_RAM_FIRST  16'h4380
`define MTR_ADDR_RAM_LAST   16'h43BF

// Data memory geometry
`define MTR_RAM_AW          6
`define MTR_RAM_DEPTH       64
`define MTR_RAM_DW          28

// Values and reset states
`define MTR_PROT_KEY_VAL    8'hAD
`define MTR_PROT_ON_VAL     8'h80
`define MTR_PROT_OFF_VAL    8'h00
`define MTR_RUN_START       16'h0001
`define MTR_RUN_STOP        16'h0000
`define MTR_RUN_RESET       16'h0000
`define MTR_CFG_RESET       16'h0010
`define MTR_MASK_RESET      32'h0000_0000

// Field positions
`define MTR_DONE_BIT        17
`define MTR_PINFN_LSB       0
`define MTR_VSEL_A_LSB      8
`define MTR_VSEL_B_LSB      10
`define MTR_VSEL_C_LSB      12
`define MTR_PINFN_DONE      2'h0
`define MTR_CAL_W           10
`define MTR_VOLT_W          24

// Timing
`define MTR_CLK_MHZ         250
`define MTR_CAL_LSB_PS      976
`define MTR_PASS_HZ         8000
`define MTR_PIN_DELAY_NS    70
`define MTR_PIN_LOW_NS      10000
`define MTR_PASS_CYC   ((`MTR_CLK_MHZ * 1000000) / `MTR_PASS_HZ)
`define MTR_PIN_DELAY_CYC ((`MTR_PIN_DELAY_NS * `MTR_CLK_MHZ + 999) / 1000)
`define MTR_PIN_LOW_CYC   ((`MTR_PIN_LOW_NS * `MTR_CLK_MHZ + 999) / 1000)

`endif

// [verilog/mtr_pkg.sv]
// Purpose: Types of the metering DSP control block.
// Assumes: Constants come from mtr_params.svh.
// Notes:   Pin sequencer codes are Gray along idle-wait-low.
`include "mtr_params.svh"
package mtr_pkg;
  typedef enum logic [1:0] {
    MTR_PIN_IDLE = 2'h0,
    MTR_PIN_WAIT = 2'h1,
    MTR_PIN_LOW  = 2'h3
  } mtr_pin_state_t;
  typedef logic [1:0]                 mtr_vsel_t;
  typedef logic [`MTR_VOLT_W-1:0]     mtr_volt_t;
  typedef logic [`MTR_RAM_DW-1:0]     mtr_word_t;
  typedef logic [`MTR_RAM_AW-1:0]     mtr_ram_addr_t;
endpackage

// [verilog/mtr_ram_if.sv]
// Purpose: Link between register front end and DSP data memory.
// Assumes: Single clock domain.
// Notes:   Protection filtering happens before wr_en.
`timescale 1ns/100ps
`default_nettype none
interface mtr_ram_if;
  import mtr_pkg::*;
  logic          ce;
  logic          clr;
  logic          wr_en;
  mtr_ram_addr_t wr_addr;
  mtr_word_t     wr_data;
  mtr_ram_addr_t rd_addr;
  mtr_word_t     rd_data;
  modport ctrl (output ce, clr, wr_en, wr_addr, wr_data, rd_addr,
                input  rd_data);
  modport mem  (input  ce, clr, wr_en, wr_addr, wr_data, rd_addr,
                output rd_data);
endinterface
`default_nettype wire

// [verilog/mtr_dsp_ram.sv]
// Purpose: DSP data memory with its two-stage write pipeline.
// Assumes: Writes arriving here already passed write protection.
// Notes:   Reads see committed contents only, never pipeline stages.
`timescale 1ns/100ps
`default_nettype none
module mtr_dsp_ram
  import mtr_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  // Memory side of the link
  mtr_ram_if.mem   ram
);
  mtr_word_t     mem_r [`MTR_RAM_DEPTH];
  logic          s1_vld_r, s1_vld_nxt, s2_vld_r, s2_vld_nxt;
  mtr_ram_addr_t s1_adr_r, s1_adr_nxt, s2_adr_r, s2_adr_nxt;
  mtr_word_t     s1_dat_r, s1_dat_nxt, s2_dat_r, s2_dat_nxt;
  logic          commit;

  // A value lands only when two later writes push it through
  always_comb begin
    s1_vld_nxt = s1_vld_r;
    s1_adr_nxt = s1_adr_r;
    s1_dat_nxt = s1_dat_r;
    s2_vld_nxt = s2_vld_r;
    s2_adr_nxt = s2_adr_r;
    s2_dat_nxt = s2_dat_r;
    commit     = 1'b0;
    if (ram.wr_en) begin
      commit     = s2_vld_r;
      s2_vld_nxt = s1_vld_r;
      s2_adr_nxt = s1_adr_r;
      s2_dat_nxt = s1_dat_r;
      s1_vld_nxt = 1'b1;
      s1_adr_nxt = ram.wr_addr;
      s1_dat_nxt = ram.wr_data;
    end
    if (ram.clr) begin
      s1_vld_nxt = 1'b0;
      s2_vld_nxt = 1'b0;
      commit     = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s1_vld_r <= 1'b0;
      s1_adr_r <= '0;
      s1_dat_r <= '0;
      s2_vld_r <= 1'b0;
      s2_adr_r <= '0;
      s2_dat_r <= '0;
      for (int i = 0; i < `MTR_RAM_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (ram.ce) begin
      s1_vld_r <= s1_vld_nxt;
      s1_adr_r <= s1_adr_nxt;
      s1_dat_r <= s1_dat_nxt;
      s2_vld_r <= s2_vld_nxt;
      s2_adr_r <= s2_adr_nxt;
      s2_dat_r <= s2_dat_nxt;
      for (int i = 0; i < `MTR_RAM_DEPTH; i++) begin
        if (ram.clr) begin
          mem_r[i] <= '0;
        end else if (commit && (s2_adr_r == i[`MTR_RAM_AW-1:0])) begin
          mem_r[i] <= s2_dat_r;
        end
      end
    end
  end

  assign ram.rd_data = mem_r[ram.rd_addr];

  property p_pipe_commit;
    @(posedge SYS_CLK_I) disable iff (!NRST_I)
    (ram.ce && ram.wr_en && s2_vld_r && !ram.clr)
      |=> (mem_r[$past(s2_adr_r)] == $past(s2_dat_r));
  endproperty
  a_pipe_commit: assert property (p_pipe_commit)
    else $error("pipelined write did not reach memory");
endmodule // mtr_dsp_ram
`default_nettype wire

// [verilog/mtr_dsp_ctrl.sv]
// Purpose: Control logic around the fixed-function metering DSP.
// Assumes: Register port is fed by the serial-port front end, same clock.
// Notes:   Phase voltages arrive from datapath logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module mtr_dsp_ctrl
  import mtr_pkg::*;
#(
  parameter int PASS_CYCLES = `MTR_PASS_CYC
) (
  // Clock, reset, enable
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  NRST_I,
  input  wire logic                  CE_I,
  input  wire logic                  SOFT_RST_I,
  // Register port
  input  wire logic                  REG_WR_I,
  input  wire logic                  REG_RD_I,
  input  wire logic [15:0]           REG_ADDR_I,
  input  wire logic [31:0]           REG_WDATA_I,
  output var  logic [31:0]           REG_RDATA_O,
  output var  logic                  REG_RVALID_O,
  // Phase voltages in and routed out
  input  wire mtr_volt_t             VOLT_A_I,
  input  wire mtr_volt_t             VOLT_B_I,
  input  wire mtr_volt_t             VOLT_C_I,
  output var  mtr_volt_t             ROUTED_A_O,
  output var  mtr_volt_t             ROUTED_B_O,
  output var  mtr_volt_t             ROUTED_C_O,
  // Calibration to the voltage delay path
  output var  logic [`MTR_CAL_W-1:0] PHASE_A_DELAY_CAL_O,
  output var  logic [`MTR_CAL_W-1:0] PHASE_B_DELAY_CAL_O,
  output var  logic [`MTR_CAL_W-1:0] PHASE_C_DELAY_CAL_O,
  // DSP sequencing
  output var  logic                  DSP_RUN_O,
  output var  logic                  PASS_DONE_O,
  // Pins
  output var  logic                  FIRST_INTERRUPT_PIN_N_O,
  output var  logic                  SHARED_EVENT_OUTPUT_PIN_O
);
  localparam int PinDelay = `MTR_PIN_DELAY_CYC;
  localparam int PinLow   = `MTR_PIN_LOW_CYC;

  mtr_ram_if u_ram_if ();

  logic                                run_r, run_nxt;
  logic                                flag_r, flag_nxt;
  logic [31:0]                         mask_r, mask_nxt;
  logic [15:0]                         cfg_r, cfg_nxt;
  logic [2:0][`MTR_CAL_W-1:0]          cal_r, cal_nxt;
  logic                                key_r, key_nxt;
  logic                                prot_r, prot_nxt;
  logic [14:0]                         cnt_r, cnt_nxt;
  logic                                pass_r, pass_nxt;
  mtr_pin_state_t                      pst_r, pst_nxt;
  logic [11:0]                         pcnt_r, pcnt_nxt;
  logic                                pin_r, pin_nxt;
  logic                                irq_n_r, irq_n_nxt;
  logic [31:0]                         rdata_r, rdata_nxt;
  logic                                rvld_r, rvld_nxt;
  logic [2:0][`MTR_VOLT_W-1:0]         vout_r, vout_nxt;
  logic [2:0][`MTR_VOLT_W-1:0]         vin;
  logic                                done_set;

  function automatic logic in_ram(input logic [15:0] a);
    in_ram = (a >= `MTR_ADDR_RAM_FIRST) && (a <= `MTR_ADDR_RAM_LAST);
  endfunction

  function automatic logic [15:0] cal_addr(input int i);
    cal_addr = (i == 0) ? `MTR_ADDR_CAL_A :
               (i == 1) ? `MTR_ADDR_CAL_B : `MTR_ADDR_CAL_C;
  endfunction

  // Rotation: 01 takes the next phase, 10 the one after, 00/11 its own
  function automatic mtr_volt_t route(input mtr_vsel_t sel,
                                      input mtr_volt_t own,
                                      input mtr_volt_t nxt1,
                                      input mtr_volt_t nxt2);
    unique case (sel)
      2'h1:    route = nxt1;
      2'h2:    route = nxt2;
      default: route = own;
    endcase
  endfunction

  assign vin = {VOLT_C_I, VOLT_B_I, VOLT_A_I};

  // Memory link; protected writes never enter the pipeline
  assign u_ram_if.ce      = CE_I;
  assign u_ram_if.clr     = SOFT_RST_I;
  assign u_ram_if.wr_en   = REG_WR_I && in_ram(REG_ADDR_I) && !prot_r
                            && !SOFT_RST_I;
  assign u_ram_if.wr_addr = REG_ADDR_I[`MTR_RAM_AW-1:0];
  assign u_ram_if.wr_data = REG_WDATA_I[`MTR_RAM_DW-1:0];
  assign u_ram_if.rd_addr = REG_ADDR_I[`MTR_RAM_AW-1:0];

  mtr_dsp_ram u_ram (
    .SYS_CLK_I (SYS_CLK_I),
    .NRST_I    (NRST_I),
    .ram       (u_ram_if.mem)
  );

  always_comb begin
    run_nxt   = run_r;
    flag_nxt  = flag_r;
    mask_nxt  = mask_r;
    cfg_nxt   = cfg_r;
    cal_nxt   = cal_r;
    key_nxt   = key_r;
    prot_nxt  = prot_r;
    cnt_nxt   = cnt_r;
    pst_nxt   = pst_r;
    pcnt_nxt  = pcnt_r;
    done_set  = 1'b0;
    rdata_nxt = 32'h0000_0000;
    rvld_nxt  = REG_RD_I;
    // Register writes; any write ends the key window
    if (REG_WR_I) begin
      key_nxt = 1'b0;
      unique case (REG_ADDR_I)
        `MTR_ADDR_RUN: begin
          if (REG_WDATA_I[15:0] == `MTR_RUN_START) begin
            run_nxt = 1'b1;
          end else if (REG_WDATA_I[15:0] == `MTR_RUN_STOP) begin
            run_nxt = 1'b0;
          end
        end
        `MTR_ADDR_STATUS_FLAGS_ZERO: begin
          if (REG_WDATA_I[`MTR_DONE_BIT]) begin
            flag_nxt = 1'b0;
          end
        end
        `MTR_ADDR_INTERRUPT_MASK_ZERO:     mask_nxt = REG_WDATA_I;
        `MTR_ADDR_CONFIG:    cfg_nxt  = REG_WDATA_I[15:0];
        `MTR_ADDR_PROT_KEY: begin
          key_nxt = (REG_WDATA_I[7:0] == `MTR_PROT_KEY_VAL);
        end
        `MTR_ADDR_PROT_CTRL: begin
          if (key_r && REG_WDATA_I[7:0] == `MTR_PROT_ON_VAL) begin
            prot_nxt = 1'b1;
          end else if (key_r && REG_WDATA_I[7:0] == `MTR_PROT_OFF_VAL) begin
            prot_nxt = 1'b0;
          end
        end
        default: ;
      endcase
      for (int i = 0; i < 3; i++) begin
        if (REG_ADDR_I == cal_addr(i)) begin
          cal_nxt[i] = REG_WDATA_I[`MTR_CAL_W-1:0];
        end
      end
    end
    // Pass timer; idles at zero while stopped
    if (run_r) begin
      if (cnt_r == 15'(PASS_CYCLES - 1)) begin
        cnt_nxt  = 15'h0000;
        done_set = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 15'h0001;
      end
    end else begin
      cnt_nxt = 15'h0000;
    end
    // Set beats a same-cycle clear so no pass end is lost
    if (done_set) begin
      flag_nxt = 1'b1;
    end
    pass_nxt = done_set;
    // Ready pulse on the shared pin; a pass end mid-pulse is not queued
    unique case (pst_r)
      MTR_PIN_IDLE: begin
        if (done_set && cfg_r[`MTR_PINFN_LSB +: 2] == `MTR_PINFN_DONE) begin
          pst_nxt  = MTR_PIN_WAIT;
          pcnt_nxt = 12'h000;
        end
      end
      MTR_PIN_WAIT: begin
        if (pcnt_r == 12'(PinDelay - 1)) begin
          pst_nxt  = MTR_PIN_LOW;
          pcnt_nxt = 12'h000;
        end else begin
          pcnt_nxt = pcnt_r + 12'h001;
        end
      end
      MTR_PIN_LOW: begin
        if (pcnt_r == 12'(PinLow - 1)) begin
          pst_nxt  = MTR_PIN_IDLE;
          pcnt_nxt = 12'h000;
        end else begin
          pcnt_nxt = pcnt_r + 12'h001;
        end
      end
      default: begin
        pst_nxt  = MTR_PIN_IDLE;
        pcnt_nxt = 12'h000;
      end
    endcase
    // Read mux; unmapped and write-only addresses read zero
    if (in_ram(REG_ADDR_I)) begin
      rdata_nxt = {4'h0, u_ram_if.rd_data};
    end else begin
      unique case (REG_ADDR_I)
        `MTR_ADDR_RUN:     rdata_nxt = {31'h0000_0000, run_r};
        `MTR_ADDR_STATUS_FLAGS_ZERO: rdata_nxt = 32'(flag_r) << `MTR_DONE_BIT;
        `MTR_ADDR_INTERRUPT_MASK_ZERO:   rdata_nxt = mask_r;
        `MTR_ADDR_CONFIG:  rdata_nxt = {16'h0000, cfg_r};
        default:           rdata_nxt = 32'h0000_0000;
      endcase
      for (int i = 0; i < 3; i++) begin
        if (REG_ADDR_I == cal_addr(i)) begin
          rdata_nxt = {22'h00_0000, cal_r[i]};
        end
      end
    end
    if (!REG_RD_I) begin
      rdata_nxt = rdata_r;
    end
    // Software reset returns all but read data, read valid and routed voltages to their power-up state
    if (SOFT_RST_I) begin
      run_nxt  = 1'b0;
      flag_nxt = 1'b0;
      mask_nxt = `MTR_MASK_RESET;
      cfg_nxt  = `MTR_CFG_RESET;
      cal_nxt  = '0;
      key_nxt  = 1'b0;
      prot_nxt = 1'b0;
      cnt_nxt  = 15'h0000;
      pass_nxt = 1'b0;
      pst_nxt  = MTR_PIN_IDLE;
      pcnt_nxt = 12'h000;
    end
    irq_n_nxt = !(flag_nxt && mask_nxt[`MTR_DONE_BIT]);
    pin_nxt   = (pst_nxt != MTR_PIN_LOW);
  end

  // Voltage substitution, one register stage
  always_comb begin
    vout_nxt[0] = route(cfg_r[`MTR_VSEL_A_LSB +: 2], vin[0], vin[1],
                        vin[2]);
    vout_nxt[1] = route(cfg_r[`MTR_VSEL_B_LSB +: 2], vin[1], vin[2],
                        vin[0]);
    vout_nxt[2] = route(cfg_r[`MTR_VSEL_C_LSB +: 2], vin[2], vin[0],
                        vin[1]);
  end

  always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      run_r   <= 1'b0;
      flag_r  <= 1'b0;
      mask_r  <= `MTR_MASK_RESET;
      cfg_r   <= `MTR_CFG_RESET;
      cal_r   <= '0;
      key_r   <= 1'b0;
      prot_r  <= 1'b0;
      cnt_r   <= 15'h0000;
      pass_r  <= 1'b0;
      pst_r   <= MTR_PIN_IDLE;
      pcnt_r  <= 12'h000;
      pin_r   <= 1'b1;
      irq_n_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
      rvld_r  <= 1'b0;
      vout_r  <= '0;
    end else if (CE_I) begin
      run_r   <= run_nxt;
      flag_r  <= flag_nxt;
      mask_r  <= mask_nxt;
      cfg_r   <= cfg_nxt;
      cal_r   <= cal_nxt;
      key_r   <= key_nxt;
      prot_r  <= prot_nxt;
      cnt_r   <= cnt_nxt;
      pass_r  <= pass_nxt;
      pst_r   <= pst_nxt;
      pcnt_r  <= pcnt_nxt;
      pin_r   <= pin_nxt;
      irq_n_r <= irq_n_nxt;
      rdata_r <= rdata_nxt;
      rvld_r  <= rvld_nxt;
      vout_r  <= vout_nxt;
    end
  end

  assign REG_RDATA_O               = rdata_r;
  assign REG_RVALID_O              = rvld_r;
  assign ROUTED_A_O                = vout_r[0];
  assign ROUTED_B_O                = vout_r[1];
  assign ROUTED_C_O                = vout_r[2];
  assign PHASE_A_DELAY_CAL_O       = cal_r[0];
  assign PHASE_B_DELAY_CAL_O       = cal_r[1];
  assign PHASE_C_DELAY_CAL_O       = cal_r[2];
  assign DSP_RUN_O                 = run_r;
  assign PASS_DONE_O               = pass_r;
  assign FIRST_INTERRUPT_PIN_N_O   = irq_n_r;
  assign SHARED_EVENT_OUTPUT_PIN_O = pin_r;

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I || SOFT_RST_I);

  property p_irq_level;
    FIRST_INTERRUPT_PIN_N_O == !(flag_r && mask_r[`MTR_DONE_BIT]);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt pin disagrees with flag and mask");

  property p_w1c;
    (CE_I && REG_WR_I && REG_ADDR_I == `MTR_ADDR_STATUS_FLAGS_ZERO
     && REG_WDATA_I[`MTR_DONE_BIT] && !done_set) |=> !flag_r && irq_n_r;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write of one did not clear done flag");

  property p_w0_keep;
    (CE_I && flag_r && REG_WR_I && REG_ADDR_I == `MTR_ADDR_STATUS_FLAGS_ZERO
     && !REG_WDATA_I[`MTR_DONE_BIT]) |=> flag_r;
  endproperty
  a_w0_keep: assert property (p_w0_keep)
    else $error("write of zero changed done flag");

  property p_pin_arm;
    (CE_I && pst_r == MTR_PIN_IDLE && done_set
     && cfg_r[1:0] == 2'h0) |=> pin_r && flag_r && pst_r == MTR_PIN_WAIT;
  endproperty
  a_pin_arm: assert property (p_pin_arm)
    else $error("ready pulse not armed at pass end");

  property p_pin_fall;
    (CE_I && pst_r == MTR_PIN_WAIT && pcnt_r == 12'(PinDelay - 1))
      |=> !pin_r;
  endproperty
  a_pin_fall: assert property (p_pin_fall)
    else $error("shared pin did not fall after delay");

  property p_pin_rise;
    (CE_I && pst_r == MTR_PIN_LOW && pcnt_r == 12'(PinLow - 1))
      |=> pin_r ##1 pin_r;
  endproperty
  a_pin_rise: assert property (p_pin_rise)
    else $error("shared pin did not return high");

  property p_run_start;
    (CE_I && REG_WR_I && REG_ADDR_I == `MTR_ADDR_RUN
     && REG_WDATA_I[15:0] == `MTR_RUN_START) |=> DSP_RUN_O;
  endproperty
  a_run_start: assert property (p_run_start)
    else $error("run write did not start DSP");

  property p_pass_needs_run;
    PASS_DONE_O |-> $past(run_r);
  endproperty
  a_pass_needs_run: assert property (p_pass_needs_run)
    else $error("pass ended while DSP idle");

  property p_prot_on;
    (CE_I && key_r && REG_WR_I && REG_ADDR_I == `MTR_ADDR_PROT_CTRL
     && REG_WDATA_I[7:0] == `MTR_PROT_ON_VAL) |=> prot_r;
  endproperty
  a_prot_on: assert property (p_prot_on)
    else $error("keyed enable did not protect memory");

  property p_prot_block;
    (prot_r && REG_WR_I && in_ram(REG_ADDR_I)) |-> !u_ram_if.wr_en;
  endproperty
  a_prot_block: assert property (p_prot_block)
    else $error("protected memory accepted a write");

  property p_route_a;
    (CE_I && cfg_r[9:8] == 2'h1) |=> ROUTED_A_O == $past(VOLT_B_I);
  endproperty
  a_route_a: assert property (p_route_a)
    else $error("phase A did not take phase B voltage");

  property p_cal_read;
    (CE_I && REG_RD_I && REG_ADDR_I == `MTR_ADDR_CAL_B)
      |=> REG_RVALID_O && REG_RDATA_O[31:10] == 22'h00_0000;
  endproperty
  a_cal_read: assert property (p_cal_read)
    else $error("calibration read has nonzero upper bits");
endmodule // mtr_dsp_ctrl
`default_nettype wire

// [sim/mtr_host_model.sv]
// Purpose: Host model driving the register port of the block.
// Assumes: Requests change only at the falling clock edge.
// Notes:   One idle cycle between accesses keeps strobes single-shot.
`timescale 1ns/100ps
`default_nettype none
module mtr_host_model (
  // Clock
  input  wire logic        clk_i,
  // Register port
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [15:0] addr_o,
  output var  logic [31:0] wdata_o,
  input  wire logic [31:0] rdata_i,
  input  wire logic        rvalid_i
);
  initial begin
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = 16'h0000;
    wdata_o = 32'h0000_0000;
  end
  // Callers keep calibration and flush order legal
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge clk_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clk_i);
    wr_o    = 1'b0;
    // Released data must not look valid
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic v);
    @(negedge clk_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    v    = rvalid_i;
    d    = rdata_i;
  endtask
endmodule // mtr_host_model
`default_nettype wire

// [sim/mtr_dsp_ctrl_tb.sv]
// Purpose: Self-checking bench of the metering DSP control block.
// Assumes: Pass length shortened to 40 cycles.
// Notes:   Pin timing counted in falling edges after the pass pulse.
`timescale 1ns/100ps
`default_nettype none
module mtr_dsp_ctrl_tb;
  import mtr_pkg::*;
  logic clk = 1'b0;
  logic nrst, srst, wr, rd, rv, run, pdone, irq_n, pin, v;
  logic [15:0] addr;
  logic [31:0] wd, rdat, d;
  logic [9:0] ca, cb, cc;
  mtr_volt_t va, vb, vc, ra, rb, rc;
  mtr_volt_t ta [4], tb [4], tc [4];
  int n_mismatch = 0;
  int compares = 0;
  int n;
  always #2 clk = ~clk;
  mtr_dsp_ctrl #(.PASS_CYCLES(40)) i_mtr_dsp_ctrl (.SYS_CLK_I(clk),
    .NRST_I(nrst), .CE_I(1'b1), .SOFT_RST_I(srst), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wd),
    .REG_RDATA_O(rdat), .REG_RVALID_O(rv), .VOLT_A_I(va), .VOLT_B_I(vb),
    .VOLT_C_I(vc), .ROUTED_A_O(ra), .ROUTED_B_O(rb), .ROUTED_C_O(rc),
    .PHASE_A_DELAY_CAL_O(ca), .PHASE_B_DELAY_CAL_O(cb),
    .PHASE_C_DELAY_CAL_O(cc), .DSP_RUN_O(run), .PASS_DONE_O(pdone),
    .FIRST_INTERRUPT_PIN_N_O(irq_n), .SHARED_EVENT_OUTPUT_PIN_O(pin));
  mtr_host_model i_mtr_host_model (.clk_i(clk), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wd), .rdata_i(rdat), .rvalid_i(rv));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    i_mtr_host_model.rd(a, d, v);
    chk("rvalid", 32'h0000_0001, 32'(v));
    chk("rdata", e, d);
  endtask
  task automatic wr3(input logic [15:0] a, input logic [31:0] x);
    repeat (3) i_mtr_host_model.wr(a, x);
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    close_out();
  end
  initial begin
    nrst = 1'b0;
    srst = 1'b0;
    va = 24'h11_1111;
    vb = 24'h22_2222;
    vc = 24'h33_3333;
    ta = '{va, vb, vc, va};
    tb = '{vb, vc, va, vb};
    tc = '{vc, va, vb, vc};
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    chk("irq", 32'h0000_0001, 32'(irq_n));
    rchk(`MTR_ADDR_RUN, 32'h0000_0000);
    rchk(`MTR_ADDR_RAM_LAST, 32'h0000_0000);
    rchk(`MTR_ADDR_CONFIG, 32'h0000_0010);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      i_mtr_host_model.wr(`MTR_ADDR_CONFIG,
                          {18'h0_0000, 2'(s), 2'(s), 2'(s), 8'h10});
      @(negedge clk);
      chk("route a", 32'(ta[s]), 32'(ra));
      chk("route b", 32'(tb[s]), 32'(rb));
      chk("route c", 32'(tc[s]), 32'(rc));
    end
    $display("test routing done");
    i_mtr_host_model.wr(`MTR_ADDR_CAL_A, 32'hFFFF_FF7F);
    i_mtr_host_model.wr(`MTR_ADDR_CAL_B, 32'h0000_017F);
    rchk(`MTR_ADDR_CAL_A, 32'h0000_037F);
    rchk(`MTR_ADDR_CAL_B, 32'h0000_017F);
    chk("cal a", 32'h0000_037F, 32'(ca));
    chk("cal b", 32'h0000_017F, 32'(cb));
    chk("cal c", 32'h0000_0000, 32'(cc));
    $display("test calibration done");
    i_mtr_host_model.wr(`MTR_ADDR_RAM_FIRST, 32'hFFFF_FFFF);
    rchk(`MTR_ADDR_RAM_FIRST, 32'h0000_0000);
    i_mtr_host_model.wr(`MTR_ADDR_RAM_LAST, 32'h0123_4567);
    i_mtr_host_model.wr(`MTR_ADDR_RAM_LAST, 32'h0123_4567);
    rchk(`MTR_ADDR_RAM_FIRST, 32'h0FFF_FFFF);
    rchk(16'h43C0, 32'h0000_0000);
    i_mtr_host_model.wr(`MTR_ADDR_PROT_KEY, 32'h0000_00AD);
    i_mtr_host_model.wr(`MTR_ADDR_PROT_CTRL, 32'h0000_0080);
    wr3(16'h4381, 32'h0000_0005);
    rchk(16'h4381, 32'h0000_0000);
    rchk(`MTR_ADDR_RAM_LAST, 32'h0000_0000);
    i_mtr_host_model.wr(`MTR_ADDR_PROT_KEY, 32'h0000_00AD);
    i_mtr_host_model.wr(`MTR_ADDR_PROT_CTRL, 32'h0000_0000);
    wr3(16'h4381, 32'h0000_0005);
    rchk(16'h4381, 32'h0000_0005);
    rchk(`MTR_ADDR_RAM_LAST, 32'h0123_4567);
    $display("test memory done");
    i_mtr_host_model.wr(`MTR_ADDR_CONFIG, 32'h0000_0010);
    i_mtr_host_model.wr(`MTR_ADDR_INTERRUPT_MASK_ZERO, 32'h0002_0000);
    i_mtr_host_model.wr(`MTR_ADDR_RUN, 32'h0000_0002);
    chk("run bad", 32'h0000_0000, 32'(run));
    i_mtr_host_model.wr(`MTR_ADDR_RUN, 32'h0000_0001);
    chk("run", 32'h0000_0001, 32'(run));
    n = 0;
    while (pdone !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("pass", 32'h0000_0001, 32'(pdone));
    chk("irq set", 32'h0000_0000, 32'(irq_n));
    n = 0;
    while (pin !== 1'b0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("pin delay", 32'(`MTR_PIN_DELAY_CYC), 32'(n));
    n = 0;
    while (pin === 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk("pin low", 32'(`MTR_PIN_LOW_CYC), 32'(n));
    i_mtr_host_model.wr(`MTR_ADDR_RUN, 32'h0000_0000);
    chk("stop", 32'h0000_0000, 32'(run));
    i_mtr_host_model.wr(`MTR_ADDR_STATUS_FLAGS_ZERO, 32'h0000_0000);
    rchk(`MTR_ADDR_STATUS_FLAGS_ZERO, 32'h0002_0000);
    i_mtr_host_model.wr(`MTR_ADDR_STATUS_FLAGS_ZERO, 32'h0002_0000);
    @(negedge clk);
    chk("irq clr", 32'h0000_0001, 32'(irq_n));
    rchk(`MTR_ADDR_STATUS_FLAGS_ZERO, 32'h0000_0000);
    $display("test pass flag done");
    i_mtr_host_model.wr(`MTR_ADDR_RUN, 32'h0000_0001);
    srst = 1'b1;
    @(negedge clk);
    srst = 1'b0;
    chk("soft run", 32'h0000_0000, 32'(run));
    rchk(`MTR_ADDR_RAM_FIRST, 32'h0000_0000);
    rchk(`MTR_ADDR_RUN, 32'h0000_0000);
    $display("test soft reset done");
    close_out();
  end
endmodule // mtr_dsp_ctrl_tb
`default_nettype wire
